// ---- src/atc_defs.vh ----
// Constants shared by the auto transfer controller design files.
`ifndef ATC_DEFS_VH
`define ATC_DEFS_VH
// Register word offsets on the Avalon-MM slave (one word per register).
`define ATC_OFS_CTRL 4'h0
`define ATC_OFS_PTR0 4'h1
`define ATC_OFS_PTR1 4'h2
`define ATC_OFS_COUNT 4'h3
`define ATC_OFS_STATUS 4'h4
`define ATC_OFS_MASK 4'h5
// Control register fields.
`define ATC_CTRL_MODE_LSB 0
`define ATC_CTRL_MODE_MSB 3
`define ATC_CTRL_INCDIS 4
`define ATC_CTRL_RESET 5'h00
// Status bits.
`define ATC_ST_DONE 0
`define ATC_ST_REFUSED 1
// I/O page placed above the low byte of pointer one.
`define ATC_IO_PAGE 10'h03f
// Mode codes handled here.
`define ATC_MODE_0 4'h0
`define ATC_MODE_1 4'h1
`define ATC_MODE_2 4'h2
`define ATC_MODE_3 4'h3
`define ATC_MODE_4 4'h4
`define ATC_MODE_5 4'h5
`define ATC_MODE_6 4'h6
`define ATC_MODE_7 4'h7
// Widths and reset values.
`define ATC_AW 18
`define ATC_ZERO_ADDR 18'h00000
`define ATC_ZERO_BYTE 8'h00
`define ATC_ONE_BYTE 8'h01
`define ATC_ONE_ADDR 18'h00001
`endif

// ---- src/atc_mode_decode.v ----
// Mode decoder: direction, byte count and pointer increments per mode.
`timescale 1ns/1ps
`include "atc_defs.vh"
module atc_mode_decode (
    // Mode select.
    input wire [3:0] mode,
    // Decoded behaviour.
    output reg valid,
    output reg twoBytes,
    output reg firstMemToIo,
    output reg swapSecond,
    output reg oddSecond,
    output reg incFirst,
    output reg incSecond
);
    // Table of modes 0 to 7; other codes are not handled and refused.
    always @* begin
        valid = 1'b1;
        twoBytes = 1'b0;
        firstMemToIo = 1'b1;
        swapSecond = 1'b0;
        oddSecond = 1'b0;
        incFirst = 1'b0;
        incSecond = 1'b0;
        case (mode) // RL18
            `ATC_MODE_0: begin
                firstMemToIo = 1'b1; // RL1
            end
            `ATC_MODE_1: begin
                firstMemToIo = 1'b0; // RL2
            end
            `ATC_MODE_2: begin
                incFirst = 1'b1; // RL4
            end
            `ATC_MODE_3: begin
                firstMemToIo = 1'b0;
                incFirst = 1'b1; // RL5
            end
            `ATC_MODE_4: begin
                twoBytes = 1'b1; // RL6
                oddSecond = 1'b1;
                incFirst = 1'b1; // RL7
                incSecond = 1'b1;
            end
            `ATC_MODE_5: begin
                firstMemToIo = 1'b0; // RL8
                twoBytes = 1'b1;
                oddSecond = 1'b1;
                incFirst = 1'b1; // RL9
                incSecond = 1'b1;
            end
            `ATC_MODE_6: begin
                firstMemToIo = 1'b0; // RL11
                twoBytes = 1'b1;
                swapSecond = 1'b1;
                incFirst = 1'b1;
                incSecond = 1'b1;
            end
            `ATC_MODE_7: begin
                firstMemToIo = 1'b0; // RL12
                twoBytes = 1'b1;
                swapSecond = 1'b1;
                incFirst = 1'b1;
            end
            default: begin
                valid = 1'b0;
            end
        endcase
    end
endmodule // atc_mode_decode

// ---- src/atc_io_addr.v ----
// Forms the 18-bit I/O address from the low byte of pointer one.
`timescale 1ns/1ps
`include "atc_defs.vh"
module atc_io_addr (
    // Pointer one low byte and odd-byte select.
    input wire [7:0] ioLow,
    input wire oddByte,
    // Resulting bus address.
    output wire [17:0] ioAddr
);
    // Upper ten bits are forced to the I/O page; odd byte sets bit 0.
    assign ioAddr = {`ATC_IO_PAGE, ioLow[7:1], ioLow[0] | oddByte}; // RL3
endmodule // atc_io_addr

// ---- src/atc_controller.v ----
// Auto transfer controller for standard transfer modes 0 to 7.
// Functional notes
// RL1: Mode 0 copies memory byte to I/O.
// RL2: Mode 1 copies I/O byte to memory.
// RL3: I/O address uses low byte, page 03F.
// RL4: Mode 2 memory to I/O, pointer zero increments.
// RL5: Mode 3 I/O to memory, pointer zero increments.
// RL6: Mode 4 word to even then odd I/O.
// RL7: Mode 4 pointer zero advances by two.
// RL8: Mode 5 word from even then odd I/O.
// RL9: Mode 5 pointer zero advances by two.
// RL10: Software programs even I/O address for words.
// RL11: Mode 6 read I/O, then write I/O.
// RL12: Mode 7 like 6, one increment only.
// RL13: Software prestores outgoing bytes at alternate locations.
// RL14: Counter decrements per activation; zero raises interrupt.
// RL15: Mode comes from first control register field.
// RL16: Increment disable bit stops pointer zero increments.
// RL17: Each byte is a load then store.
// RL18: Four-bit mode codes decoded into behaviour.
//
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`include "atc_defs.vh"
module atc_controller (
    // Clock and reset.
    input wire ref_clk,
    input wire rst_b,
    // Avalon-MM register slave.
    input wire [3:0] avsAddress,
    input wire avsRead,
    input wire avsWrite,
    input wire [31:0] avsWriteData,
    output wire [31:0] avsReadData,
    output wire avsWaitRequest,
    // Activation request, one-cycle pulse.
    input wire actReq,
    // Memory bus master towards the core bus.
    output wire [17:0] memAddr,
    output wire memRead,
    output wire memWrite,
    output wire [7:0] memWriteData,
    input wire [7:0] memReadData,
    input wire memWaitRequest,
    // Interrupt and state.
    output wire transferDoneIrq,
    output wire busy
);
    ////////////////////////////////////////////////////////////////////////
    // States, one-hot.
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_LOAD = 4'b0010;
    localparam [3:0] ST_STORE = 4'b0100;
    localparam [3:0] ST_NEXT = 4'b1000;

    reg [4:0] ctrl_ff;
    reg [17:0] ptr0_ff;
    reg [17:0] ptr1_ff;
    reg [7:0] count_ff;
    reg [1:0] status_ff;
    reg [1:0] mask_ff;
    reg [3:0] state_ff;
    reg secondByte_ff;
    reg [7:0] data_ff;
    reg [17:0] memAddr_ff;
    reg memRead_ff;
    reg memWrite_ff;
    reg [31:0] rdData_ff;
    reg rdAck_ff;
    reg irq_ff;
    reg [3:0] nxt_state;

    wire modeValid;
    wire twoBytes;
    wire firstMemToIo;
    wire swapSecond;
    wire oddSecond;
    wire incFirst;
    wire incSecond;
    wire [17:0] ioAddr;
    wire memToIo;
    wire incNow;
    wire incDisable;
    wire startOk;
    wire busDone;
    wire doneEvent;
    wire refuseEvent;
    wire regWrite;
    wire [17:0] srcAddr;
    wire [17:0] dstAddr;
    wire secondMemToIo;
    wire [17:0] ptr0Next;
    wire [17:0] ioOdd;
    wire [17:0] secondSrc;

    ////////////////////////////////////////////////////////////////////////
    // Decoder and I/O address former.
    atc_mode_decode uDecode (
        .mode(ctrl_ff[`ATC_CTRL_MODE_MSB:`ATC_CTRL_MODE_LSB]), // RL15
        .valid(modeValid),
        .twoBytes(twoBytes),
        .firstMemToIo(firstMemToIo),
        .swapSecond(swapSecond),
        .oddSecond(oddSecond),
        .incFirst(incFirst),
        .incSecond(incSecond)
    );

    atc_io_addr uIoAddr (
        .ioLow(ptr1_ff[7:0]),
        .oddByte(secondByte_ff & oddSecond),
        .ioAddr(ioAddr)
    );

    // Direction of the current byte; modes 6 and 7 reverse on the second.
    assign memToIo = firstMemToIo ^ (secondByte_ff & swapSecond);
    assign srcAddr = memToIo ? ptr0_ff : ioAddr;
    assign dstAddr = memToIo ? ioAddr : ptr0_ff;
    assign incDisable = ctrl_ff[`ATC_CTRL_INCDIS];
    // Increment after the current byte, unless disabled.
    assign incNow = (secondByte_ff ? incSecond : incFirst) & ~incDisable; // RL16
    assign busDone = (memRead_ff | memWrite_ff) & ~memWaitRequest;
    // Requests are refused and flagged with a zero counter or an unhandled mode.
    assign startOk = (count_ff != `ATC_ZERO_BYTE) & modeValid; // RL14
    assign refuseEvent = actReq & (state_ff == ST_IDLE) & ~startOk;
    assign doneEvent = (state_ff == ST_NEXT) & (~twoBytes | secondByte_ff) & (count_ff == `ATC_ONE_BYTE);
    assign regWrite = avsWrite & (state_ff == ST_IDLE);
    // Second-byte source is formed ahead of the pointer step that lands at the same edge.
    assign secondMemToIo = firstMemToIo ^ swapSecond; // RL11 RL12
    assign ptr0Next = incNow ? (ptr0_ff + `ATC_ONE_ADDR) : ptr0_ff;
    assign ioOdd = {`ATC_IO_PAGE, ptr1_ff[7:1], ptr1_ff[0] | oddSecond}; // RL3 RL6 RL8
    assign secondSrc = secondMemToIo ? ptr0Next : ioOdd;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer next state.
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (actReq & startOk & ~avsWrite) begin
                    nxt_state = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (busDone) begin
                    nxt_state = ST_STORE; // RL17
                end
            end
            ST_STORE: begin
                if (busDone) begin
                    nxt_state = ST_NEXT;
                end
            end
            ST_NEXT: begin
                if (twoBytes & ~secondByte_ff) begin
                    nxt_state = ST_LOAD;
                end else begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer, bus master and second-byte flag.
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= ST_IDLE;
            secondByte_ff <= 1'b0;
            data_ff <= `ATC_ZERO_BYTE;
            memAddr_ff <= `ATC_ZERO_ADDR;
            memRead_ff <= 1'b0;
            memWrite_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            // Load cycle reads the source address.
            if ((nxt_state == ST_LOAD) & (state_ff != ST_LOAD)) begin
                memRead_ff <= 1'b1; // RL17
                memAddr_ff <= (state_ff == ST_NEXT) ? secondSrc : srcAddr;
            end
            if ((state_ff == ST_LOAD) & busDone) begin
                memRead_ff <= 1'b0;
                data_ff <= memReadData;
                memWrite_ff <= 1'b1; // RL17
                memAddr_ff <= dstAddr;
            end
            if ((state_ff == ST_STORE) & busDone) begin
                memWrite_ff <= 1'b0;
            end
            if (state_ff == ST_NEXT) begin
                secondByte_ff <= twoBytes & ~secondByte_ff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers: control, pointers, counter, status and mask.
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_ff <= `ATC_CTRL_RESET;
            ptr0_ff <= `ATC_ZERO_ADDR;
            ptr1_ff <= `ATC_ZERO_ADDR;
            count_ff <= `ATC_ZERO_BYTE;
            status_ff <= 2'h0;
            mask_ff <= 2'h0;
        end else begin
            if (regWrite) begin
                case (avsAddress)
                    `ATC_OFS_CTRL: ctrl_ff <= avsWriteData[4:0];
                    `ATC_OFS_PTR0: ptr0_ff <= avsWriteData[17:0];
                    `ATC_OFS_PTR1: ptr1_ff <= avsWriteData[17:0];
                    `ATC_OFS_COUNT: count_ff <= avsWriteData[7:0];
                    `ATC_OFS_MASK: mask_ff <= avsWriteData[1:0];
                    default: begin
                    end
                endcase
            end
            // Pointer zero steps after a finished byte move.
            if ((state_ff == ST_NEXT) & incNow) begin
                ptr0_ff <= ptr0_ff + `ATC_ONE_ADDR; // RL4 RL5 RL7 RL9 RL11 RL12
            end
            // One decrement per activation, after its last byte.
            if ((state_ff == ST_NEXT) & (~twoBytes | secondByte_ff)) begin
                count_ff <= count_ff - `ATC_ONE_BYTE; // RL14
            end
            // Sticky status: a new event wins over a write-one clear.
            status_ff[`ATC_ST_DONE] <= doneEvent |
                (status_ff[`ATC_ST_DONE] & ~(regWrite & (avsAddress == `ATC_OFS_STATUS) &
                avsWriteData[`ATC_ST_DONE])); // RL14
            status_ff[`ATC_ST_REFUSED] <= refuseEvent |
                (status_ff[`ATC_ST_REFUSED] & ~(regWrite & (avsAddress == `ATC_OFS_STATUS) &
                avsWriteData[`ATC_ST_REFUSED]));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path; a write is held off while a transfer runs.
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdData_ff <= 32'h00000000;
            rdAck_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(status_ff & mask_ff);
            rdAck_ff <= avsRead & ~rdAck_ff;
            if (avsRead & ~rdAck_ff) begin
                case (avsAddress)
                    `ATC_OFS_CTRL: rdData_ff <= {27'h0, ctrl_ff};
                    `ATC_OFS_PTR0: rdData_ff <= {14'h0, ptr0_ff};
                    `ATC_OFS_PTR1: rdData_ff <= {14'h0, ptr1_ff};
                    `ATC_OFS_COUNT: rdData_ff <= {24'h0, count_ff};
                    `ATC_OFS_STATUS: rdData_ff <= {30'h0, status_ff};
                    `ATC_OFS_MASK: rdData_ff <= {30'h0, mask_ff};
                    default: rdData_ff <= 32'h00000000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops except the bus wait combination.
    assign avsReadData = rdData_ff;
    assign avsWaitRequest = (avsRead & ~rdAck_ff) | (avsWrite & (state_ff != ST_IDLE));
    assign memAddr = memAddr_ff;
    assign memRead = memRead_ff;
    assign memWrite = memWrite_ff;
    assign memWriteData = data_ff;
    assign transferDoneIrq = irq_ff;
    assign busy = ~state_ff[0];
endmodule // atc_controller

// ---- sim/atc_ctrl_chk.sv ----
// Port checker for the auto transfer controller.
`timescale 1ns/1ps
module atc_ctrl_chk (
    // Clock and reset.
    input wire ref_clk,
    input wire rst_b,
    // Register bus.
    input wire [3:0] avsAddress,
    input wire avsWrite,
    input wire [31:0] avsWriteData,
    input wire avsWaitRequest,
    // Activation, memory bus and state.
    input wire actReq,
    input wire [17:0] memAddr,
    input wire memRead,
    input wire memWrite,
    input wire [7:0] memWriteData,
    input wire [7:0] memReadData,
    input wire memWaitRequest,
    input wire transferDoneIrq,
    input wire busy
);
    reg [3:0] mode_ff;
    reg [7:0] ioLow_ff;
    reg mask_ff;
    reg [7:0] load_ff;
    wire wrOk = avsWrite && !avsWaitRequest;
    wire [17:0] ioAddr = {10'h03f, ioLow_ff};
    // Shadows of mode, pointer one low byte, any-mask-bit flag and last loaded byte.
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_ff <= 4'h0;
            ioLow_ff <= 8'h00;
            mask_ff <= 1'b0;
            load_ff <= 8'h00;
        end else begin
            if (wrOk && avsAddress == 4'h0) mode_ff <= avsWriteData[3:0];
            if (wrOk && avsAddress == 4'h2) ioLow_ff <= avsWriteData[7:0];
            if (wrOk && avsAddress == 4'h5) mask_ff <= |avsWriteData[1:0];
            if (memRead && !memWaitRequest) load_ff <= memReadData;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence s_load; memRead && !memWaitRequest; endsequence
    sequence s_store; memWrite; endsequence
    property p_load_store; s_load |=> s_store; endproperty
    property p_store_data; memWrite |-> memWriteData == load_ff; endproperty
    property p_idle; !busy |-> !memRead && !memWrite; endproperty
    property p_to_io; memWrite && (mode_ff == 4'h0 || mode_ff == 4'h2) |-> memAddr == ioAddr; endproperty
    property p_from_io; memRead && (mode_ff == 4'h1 || mode_ff == 4'h3) |-> memAddr == ioAddr; endproperty
    property p_word; (memWrite && mode_ff == 4'h4) || (memRead && mode_ff == 4'h5) |-> memAddr[17:1] == ioAddr[17:1];
    endproperty
    property p_start; $rose(busy) |-> $past(actReq); endproperty
    property p_first_load; $rose(busy) |-> ##[0:2] memRead; endproperty
    property p_mode; $rose(busy) |-> mode_ff <= 4'h7; endproperty
    property p_irq; transferDoneIrq |-> $past(mask_ff); endproperty
    a_load_store: assert property (p_load_store) else $error("no store after load");
    a_store_data: assert property (p_store_data) else $error("stored byte differs");
    a_idle: assert property (p_idle) else $error("bus cycle while idle");
    a_to_io: assert property (p_to_io) else $error("bad I/O destination");
    a_from_io: assert property (p_from_io) else $error("bad I/O source");
    a_word: assert property (p_word) else $error("word I/O address off pair");
    a_start: assert property (p_start) else $error("start without request");
    a_first_load: assert property (p_first_load) else $error("no load after start");
    a_mode: assert property (p_mode) else $error("start with unknown mode");
    a_irq: assert property (p_irq) else $error("interrupt while masked");
endmodule // atc_ctrl_chk
bind atc_controller atc_ctrl_chk atc_ctrl_chk_inst (.ref_clk(ref_clk), .rst_b(rst_b), .avsAddress(avsAddress),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsWaitRequest(avsWaitRequest), .actReq(actReq),
    .memAddr(memAddr), .memRead(memRead), .memWrite(memWrite), .memWriteData(memWriteData),
    .memReadData(memReadData), .memWaitRequest(memWaitRequest), .transferDoneIrq(transferDoneIrq), .busy(busy));

// ---- sim/atc_mem_model.sv ----
// Behavioural memory and register space on the core bus.
`timescale 1ns/1ps
module atc_mem_model (
    // Clock and wait states.
    input wire ref_clk,
    input wire [3:0] waitCycles,
    // Core bus slave side.
    input wire [17:0] memAddr,
    input wire memRead,
    input wire memWrite,
    input wire [7:0] memWriteData,
    output wire [7:0] memReadData,
    output wire memWaitRequest
);
    logic [7:0] mem [0:262143];
    logic [3:0] waitCnt = 4'h0;
    wire req = memRead || memWrite;
    // Stall each cycle until the chosen number of wait cycles has passed.
    assign memWaitRequest = req && (waitCnt != waitCycles);
    // Outside a read the lines carry the inverse, never the stored byte.
    assign memReadData = memRead ? mem[memAddr] : ~mem[memAddr];
    // Count wait cycles and take a store at its accepting edge.
    always @(posedge ref_clk) begin
        waitCnt <= (!req || !memWaitRequest) ? 4'h0 : waitCnt + 4'h1;
        if (memWrite && !memWaitRequest) mem[memAddr] <= memWriteData;
    end
endmodule // atc_mem_model

// ---- sim/tb_top.sv ----
// Self-checking testbench for the auto transfer controller.
`timescale 1ns/1ps
`include "atc_defs.vh"
module tb_top;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] avsAddress = 4'h0;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h00000000;
    logic actReq = 1'b0;
    logic [3:0] waitCycles = 4'h0;
    wire [31:0] avsReadData;
    wire avsWaitRequest, memRead, memWrite, memWaitRequest, transferDoneIrq, busy;
    wire [17:0] memAddr;
    wire [7:0] memWriteData, memReadData;
    int n_mismatch = 0;
    int num_checks = 0;
    logic [31:0] rd;
    logic [17:0] p0, io;
    logic [31:0] expTab [9] = '{32'h11441122, 32'h33443322, 32'h11441122, 32'h33443322,
        32'h11221122, 32'h33443344, 32'h22443322, 32'h22443322, 32'h33443322};
    int dpTab [9] = '{0, 0, 1, 1, 2, 2, 2, 1, 0};
    always #10 ref_clk = ~ref_clk;
    atc_controller atc_controller_inst (.ref_clk(ref_clk), .rst_b(rst_b), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .actReq(actReq), .memAddr(memAddr), .memRead(memRead),
        .memWrite(memWrite), .memWriteData(memWriteData), .memReadData(memReadData),
        .memWaitRequest(memWaitRequest), .transferDoneIrq(transferDoneIrq), .busy(busy));
    atc_mem_model atc_mem_model_inst (.ref_clk(ref_clk), .waitCycles(waitCycles), .memAddr(memAddr),
        .memRead(memRead), .memWrite(memWrite), .memWriteData(memWriteData),
        .memReadData(memReadData), .memWaitRequest(memWaitRequest));
    ////////////////////////////////////////////////////////////////////////////////
    // Compares one value and reports a difference.
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One register bus access, held until waitrequest is seen low.
    task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge ref_clk);
        avsAddress <= a;
        avsWriteData <= d;
        avsWrite <= wr;
        avsRead <= !wr;
        do begin
            @(posedge ref_clk);
            t++;
        end while (avsWaitRequest !== 1'b0 && t < 2000);
        if (t >= 2000) begin
            n_mismatch++;
            final_report();
        end
        rd = avsReadData;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask
    // Pulses the activation request and waits for the controller to go idle.
    task automatic activate();
        int t;
        t = 0;
        @(posedge ref_clk);
        actReq <= 1'b1;
        @(posedge ref_clk);
        actReq <= 1'b0;
        // One more edge so that busy reflects the request just taken.
        @(posedge ref_clk);
        while (busy !== 1'b0 && t < 2000) begin
            @(posedge ref_clk);
            t++;
        end
        if (t >= 2000) begin
            n_mismatch++;
            final_report();
        end
        repeat (2) @(posedge ref_clk);
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic final_report();
        $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Every mode once, plus mode six with pointer increments disabled.
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        avs(1'b0, `ATC_OFS_CTRL, 32'h00000000);
        check("ctrl reset", 32'h00000000, rd);
        avs(1'b1, `ATC_OFS_MASK, 32'h00000001);
        for (int i = 0; i < 9; i++) begin
            p0 = 18'h10000 + 18'(i * 16);
            io = 18'h03f20 + 18'(i * 2);
            waitCycles <= 4'(i % 4);
            atc_mem_model_inst.mem[p0] = 8'h11;
            atc_mem_model_inst.mem[p0 + 18'h00001] = 8'h22;
            atc_mem_model_inst.mem[io] = 8'h33;
            atc_mem_model_inst.mem[io + 18'h00001] = 8'h44;
            avs(1'b1, `ATC_OFS_CTRL, (i == 8) ? 32'h00000016 : 32'(i));
            avs(1'b1, `ATC_OFS_PTR0, {14'h0000, p0});
            avs(1'b1, `ATC_OFS_PTR1, 32'h0003ff20 + 32'(i * 2));
            avs(1'b1, `ATC_OFS_COUNT, 32'h00000001);
            activate();
            check("bytes", expTab[i], {atc_mem_model_inst.mem[io], atc_mem_model_inst.mem[io + 18'h00001],
                atc_mem_model_inst.mem[p0], atc_mem_model_inst.mem[p0 + 18'h00001]});
            avs(1'b0, `ATC_OFS_PTR0, 32'h00000000);
            check("ptr0", 32'(p0) + 32'(dpTab[i]), rd);
            avs(1'b0, `ATC_OFS_STATUS, 32'h00000000);
            check("done", 32'h00000001, rd & 32'h00000001);
            check("irq", 32'h00000001, {31'h00000000, transferDoneIrq});
            avs(1'b1, `ATC_OFS_STATUS, 32'h00000003);
        end
        // Two activations, masked interrupt, then a request after the count ran out.
        avs(1'b1, `ATC_OFS_MASK, 32'h00000000);
        avs(1'b1, `ATC_OFS_CTRL, 32'h00000002);
        avs(1'b1, `ATC_OFS_PTR0, 32'h00020000);
        avs(1'b1, `ATC_OFS_COUNT, 32'h00000002);
        activate();
        avs(1'b0, `ATC_OFS_STATUS, 32'h00000000);
        check("early done", 32'h00000000, rd & 32'h00000001);
        activate();
        avs(1'b0, `ATC_OFS_STATUS, 32'h00000000);
        check("late done", 32'h00000001, rd & 32'h00000001);
        check("masked irq", 32'h00000000, {31'h00000000, transferDoneIrq});
        avs(1'b1, `ATC_OFS_MASK, 32'h00000001);
        repeat (2) @(posedge ref_clk);
        check("unmasked irq", 32'h00000001, {31'h00000000, transferDoneIrq});
        activate();
        avs(1'b0, `ATC_OFS_PTR0, 32'h00000000);
        check("ptr0 after end", 32'h00020002, rd);
        avs(1'b0, `ATC_OFS_STATUS, 32'h00000000);
        check("refused", 32'h00000003, rd);
        avs(1'b0, 4'hf, 32'h00000000);
        check("unmapped", 32'h00000000, rd);
        final_report();
    end
    // Cuts a hang short.
    initial begin
        #400000;
        n_mismatch++;
        final_report();
    end
endmodule // tb_top
